/* File: hw/supervisor_pkg.sv */
// shared constants for the supply supervisor
package supervisor_pkg;
  localparam int unsigned CLK_HZ = 100_000_000;
  localparam int unsigned CLK_NS = 10;
  // reset hold in ms, watchdog timeout in ms, shortest kick pulse in ns
  localparam int unsigned HOLD_MS = 200;
  localparam int unsigned WDOG_MS = 1600;
  localparam int unsigned KICK_MIN_NS = 50;
  localparam int unsigned HOLD_CYCLES = HOLD_MS * (CLK_HZ / 1000);
  localparam int unsigned WDOG_CYCLES = WDOG_MS * (CLK_HZ / 1000);
  localparam int unsigned KICK_MIN_CYCLES =
    (KICK_MIN_NS + CLK_NS - 1) / CLK_NS;
  // cycles per timebase tick
  localparam int unsigned TICK_CYCLES = 1000;
  localparam int unsigned CNT_W = 32;
  localparam logic [CNT_W-1:0] CNT_ZERO = 32'h0000_0000;
  localparam logic [CNT_W-1:0] CNT_ONE = 32'h0000_0001;
  localparam logic [1:0] SYNC_IDLE_HI = 2'h3;
  localparam logic [1:0] SYNC_IDLE_LO = 2'h0;
  // reset generator states, gray along power-up path
  typedef enum logic [1:0] {
    ST_ASSERT = 2'b00,
    ST_HOLD = 2'b01,
    ST_RUN = 2'b11
  } rst_state_t;
endpackage : supervisor_pkg

/* File: hw/sync2.sv */
// two-flop synchroniser for one level
`timescale 1ns/1ps
`default_nettype none
module sync2 #(
  parameter logic INIT = 1'b0
) (
  // clock and reset
  input wire logic clk_in,
  input wire logic rst_n_in,
  // level
  input wire logic d_in,
  output logic q_out
);
  logic meta_r;
  // first stage read only by second
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      meta_r <= INIT;
      q_out <= INIT;
    end else begin
      meta_r <= d_in;
      q_out <= meta_r;
    end
  end
endmodule : sync2
`default_nettype wire

/* File: hw/tick_counter.sv */
// timebase-driven timeout counter with clear
`timescale 1ns/1ps
`default_nettype none
module tick_counter (
  // clock and reset
  input wire logic clk_in,
  input wire logic rst_n_in,
  // control
  input wire logic clear_in,
  input wire logic tick_in,
  input wire logic [31:0] limit_in,
  // status
  output logic done_out
);
  logic [31:0] cnt_r;
  logic [31:0] cnt_nxt;
  wire at_limit = (cnt_r >= limit_in);
  assign cnt_nxt = clear_in ? supervisor_pkg::CNT_ZERO :
    ((tick_in && !at_limit) ? cnt_r + supervisor_pkg::CNT_ONE : cnt_r);
  // saturating count so done stays until cleared
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      cnt_r <= supervisor_pkg::CNT_ZERO;
      done_out <= 1'b0;
    end else begin
      cnt_r <= cnt_nxt;
      done_out <= !clear_in && (cnt_nxt >= limit_in);
    end
  end
endmodule : tick_counter
`default_nettype wire

/* File: hw/supply_supervisor_reset_watchdog.sv */
// supply supervisor: timed reset, watchdog, power-fail flag
// Contract
// RULE1 - reset on supply low or manual low
// RULE2 - hold reset 200 ms after supply recovers
// RULE3 - hold reset 200 ms after manual rises
// RULE4 - new trigger restarts full hold time
// RULE5 - watchdog expiry never asserts reset itself
// RULE6 - active-high reset inverts active-low reset
// RULE7 - manual low resets, input is debounced
// RULE8 - debounce comes from hold period only
// RULE9 - floating manual input reads inactive high
// RULE10 - power-fail flag low when sense low
// RULE11 - static kick beyond timeout drives flag low
// RULE12 - any kick edge clears watchdog counter
// RULE13 - watchdog counter held clear during reset
// RULE14 - floating kick input disables the watchdog
// RULE15 - expired flag stays low until cleared
// RULE16 - supply low forces flag low, no delay
// RULE17 - watchdog timeout is 1.6 seconds
// RULE18 - kick pulses of 50 ns detected
// RULE19 - timers count timebase ticks, inputs synchronised
`timescale 1ns/1ps
`default_nettype none
module supply_supervisor_reset_watchdog #(
  parameter int unsigned TICK_CYCLES = supervisor_pkg::TICK_CYCLES,
  parameter int unsigned HOLD_CYCLES = supervisor_pkg::HOLD_CYCLES,
  parameter int unsigned WDOG_CYCLES = supervisor_pkg::WDOG_CYCLES
) (
  // clock and reset
  input wire logic REF_CLK_IN,
  input wire logic RESET_N_IN,
  // comparator results, high means supply or sense is low
  input wire logic SUPPLY_LOW_IN,
  input wire logic POWER_FAIL_SENSE_LOW_IN,
  // manual reset, with pull-up already applied by the pad model
  input wire logic MANUAL_RESET_N_INPUT_IN,
  // three-level kick: level plus a driven indication
  input wire logic WATCHDOG_KICK_INPUT_IN,
  input wire logic WATCHDOG_KICK_DRIVEN_IN,
  // outputs to the host
  output logic SYS_RESET_N_OUT,
  output logic SYS_RESET_OUT,
  output logic WATCHDOG_EXPIRED_N_OUT,
  output logic POWER_FAIL_FLAG_N_OUT
);
  // synchronised inputs
  logic supply_low_s;
  logic pf_low_s;
  logic mr_n_s;
  logic kick_s;
  logic kick_drv_s;
  logic kick_prev_r;
  logic kick_drv_prev_r;
  logic [supervisor_pkg::CNT_W-1:0] tick_cnt_r;
  logic tick_r;
  logic [supervisor_pkg::CNT_W-1:0] hold_cnt_r;
  logic [supervisor_pkg::CNT_W-1:0] hold_cnt_nxt;
  supervisor_pkg::rst_state_t state_r;
  supervisor_pkg::rst_state_t state_nxt;
  logic wd_done;

  // comparator flags enter through synchronisers
  sync2 #(.INIT(1'b1)) u_sync_supply ( // RULE19
    .clk_in(REF_CLK_IN), .rst_n_in(RESET_N_IN),
    .d_in(SUPPLY_LOW_IN), .q_out(supply_low_s));
  sync2 #(.INIT(1'b0)) u_sync_pf ( // RULE19
    .clk_in(REF_CLK_IN), .rst_n_in(RESET_N_IN),
    .d_in(POWER_FAIL_SENSE_LOW_IN), .q_out(pf_low_s));
  // idle high so a floating manual pin is inactive
  sync2 #(.INIT(1'b1)) u_sync_mr ( // RULE9
    .clk_in(REF_CLK_IN), .rst_n_in(RESET_N_IN),
    .d_in(MANUAL_RESET_N_INPUT_IN), .q_out(mr_n_s));
  // kick is sampled every 10 ns, so a 50 ns pulse is seen
  sync2 #(.INIT(1'b0)) u_sync_kick ( // RULE18
    .clk_in(REF_CLK_IN), .rst_n_in(RESET_N_IN),
    .d_in(WATCHDOG_KICK_INPUT_IN), .q_out(kick_s));
  sync2 #(.INIT(1'b0)) u_sync_kdrv (
    .clk_in(REF_CLK_IN), .rst_n_in(RESET_N_IN),
    .d_in(WATCHDOG_KICK_DRIVEN_IN), .q_out(kick_drv_s));

  // free-running timebase, one pulse every TICK_CYCLES
  wire tick_wrap = (tick_cnt_r == 32'(TICK_CYCLES - 1));
  always_ff @(posedge REF_CLK_IN) begin
    if (!RESET_N_IN) begin
      tick_cnt_r <= supervisor_pkg::CNT_ZERO;
      tick_r <= 1'b0;
    end else begin
      tick_cnt_r <= tick_wrap ? supervisor_pkg::CNT_ZERO :
        tick_cnt_r + supervisor_pkg::CNT_ONE;
      tick_r <= tick_wrap; // RULE19
    end
  end

  // hold limit in ticks, rounded up
  localparam int unsigned HOLD_TICKS =
    (HOLD_CYCLES + TICK_CYCLES - 1) / TICK_CYCLES;
  localparam int unsigned WDOG_TICKS = WDOG_CYCLES / TICK_CYCLES;

  // any trigger present; watchdog flag is not one of them
  wire trigger = supply_low_s || !mr_n_s; // RULE1 RULE5 RULE7
  wire hold_done = (hold_cnt_r >= 32'(HOLD_TICKS));

  // reset generator: trigger parks in assert, hold restarts
  always_comb begin
    state_nxt = state_r;
    hold_cnt_nxt = hold_cnt_r;
    case (state_r)
      supervisor_pkg::ST_ASSERT: begin
        hold_cnt_nxt = supervisor_pkg::CNT_ZERO;
        if (!trigger) begin
          state_nxt = supervisor_pkg::ST_HOLD; // RULE2 RULE3
        end
      end
      supervisor_pkg::ST_HOLD: begin
        if (trigger) begin
          // retrigger restarts full period; this is the debounce
          state_nxt = supervisor_pkg::ST_ASSERT; // RULE4 RULE8
          hold_cnt_nxt = supervisor_pkg::CNT_ZERO;
        end else if (hold_done) begin
          state_nxt = supervisor_pkg::ST_RUN;
        end else if (tick_r) begin
          hold_cnt_nxt = hold_cnt_r + supervisor_pkg::CNT_ONE;
        end
      end
      supervisor_pkg::ST_RUN: begin
        if (trigger) begin
          state_nxt = supervisor_pkg::ST_ASSERT; // RULE1
        end
      end
      default: begin
        state_nxt = supervisor_pkg::ST_ASSERT;
        hold_cnt_nxt = supervisor_pkg::CNT_ZERO;
      end
    endcase
  end

  always_ff @(posedge REF_CLK_IN) begin
    if (!RESET_N_IN) begin
      state_r <= supervisor_pkg::ST_ASSERT;
      hold_cnt_r <= supervisor_pkg::CNT_ZERO;
    end else begin
      state_r <= state_nxt;
      hold_cnt_r <= hold_cnt_nxt;
    end
  end

  wire reset_active_nxt = (state_nxt != supervisor_pkg::ST_RUN);
  wire reset_active = (state_r != supervisor_pkg::ST_RUN);

  // kick edge detector on the synchronised level
  always_ff @(posedge REF_CLK_IN) begin
    if (!RESET_N_IN) begin
      kick_prev_r <= 1'b0;
      kick_drv_prev_r <= 1'b0;
    end else begin
      kick_prev_r <= kick_s;
      kick_drv_prev_r <= kick_drv_s;
    end
  end
  wire kick_edge = (kick_s != kick_prev_r) ||
    (kick_drv_s != kick_drv_prev_r); // RULE12
  // floating kick keeps counter clear, so it never expires
  wire wd_clear = kick_edge || reset_active || !kick_drv_s; // RULE13 RULE14

  localparam logic [31:0] WDOG_LIMIT = 32'(WDOG_TICKS);
  tick_counter u_wdog ( // RULE17
    .clk_in(REF_CLK_IN),
    .rst_n_in(RESET_N_IN),
    .clear_in(wd_clear),
    .tick_in(tick_r),
    .limit_in(WDOG_LIMIT),
    .done_out(wd_done)
  );

  // outputs straight from flops
  always_ff @(posedge REF_CLK_IN) begin
    if (!RESET_N_IN) begin
      SYS_RESET_N_OUT <= 1'b0;
      SYS_RESET_OUT <= 1'b1;
      WATCHDOG_EXPIRED_N_OUT <= 1'b0;
      POWER_FAIL_FLAG_N_OUT <= 1'b1;
    end else begin
      SYS_RESET_N_OUT <= !reset_active_nxt;
      SYS_RESET_OUT <= reset_active_nxt; // RULE6
      // supply term has no hold delay, unlike reset
      WATCHDOG_EXPIRED_N_OUT <= !(wd_done || supply_low_s); // RULE11 RULE15 RULE16
      POWER_FAIL_FLAG_N_OUT <= !pf_low_s; // RULE10
    end
  end

  // checks
  AST_POLARITY: assert property (@(posedge REF_CLK_IN) // RULE6
    disable iff (!RESET_N_IN) SYS_RESET_OUT == !SYS_RESET_N_OUT)
    else $error("reset outputs not inverse");
  AST_TRIGGER_RESET: assert property (@(posedge REF_CLK_IN) // RULE1
    disable iff (!RESET_N_IN) trigger |=> !SYS_RESET_N_OUT)
    else $error("trigger did not assert reset");
  AST_HOLD_AFTER_RELEASE: assert property (@(posedge REF_CLK_IN) // RULE2
    disable iff (!RESET_N_IN)
    $fell(trigger) |-> !SYS_RESET_N_OUT [*8])
    else $error("reset released too early after trigger");
  AST_RETRIGGER: assert property (@(posedge REF_CLK_IN) // RULE4
    disable iff (!RESET_N_IN)
    (state_r == supervisor_pkg::ST_HOLD && trigger)
    |=> state_r == supervisor_pkg::ST_ASSERT &&
    hold_cnt_r == supervisor_pkg::CNT_ZERO)
    else $error("retrigger did not restart hold");
  AST_MR_RESET: assert property (@(posedge REF_CLK_IN) // RULE7
    disable iff (!RESET_N_IN) !mr_n_s |=> !SYS_RESET_N_OUT)
    else $error("manual low did not reset");
  AST_PFO: assert property (@(posedge REF_CLK_IN) // RULE10
    disable iff (!RESET_N_IN) POWER_FAIL_FLAG_N_OUT == !$past(pf_low_s))
    else $error("power-fail flag wrong");
  AST_WD_CLEAR_RESET: assert property (@(posedge REF_CLK_IN) // RULE13
    disable iff (!RESET_N_IN) reset_active |=> ##1 !wd_done)
    else $error("watchdog counted during reset");
  // supply may drop in between, which forces the flag low on its own
  AST_WD_FLOAT: assert property (@(posedge REF_CLK_IN) // RULE14
    disable iff (!RESET_N_IN) (!kick_drv_s && !supply_low_s)
    |=> ##1 (WATCHDOG_EXPIRED_N_OUT || $past(supply_low_s)))
    else $error("floating kick still expired");
  AST_WD_SUPPLY: assert property (@(posedge REF_CLK_IN) // RULE16
    disable iff (!RESET_N_IN) supply_low_s |=> !WATCHDOG_EXPIRED_N_OUT)
    else $error("watchdog flag not forced by supply low");
  AST_WD_STICKY: assert property (@(posedge REF_CLK_IN) // RULE15
    disable iff (!RESET_N_IN)
    (wd_done && !wd_clear) |=> wd_done)
    else $error("expiry dropped without clear");

  // reset generator: the run state always has reset released
  AST_RUN_RELEASED: assert property (@(posedge REF_CLK_IN) // RULE2
    disable iff (!RESET_N_IN)
    state_r == supervisor_pkg::ST_RUN |-> SYS_RESET_N_OUT)
    else $error("run state with reset still asserted");

  // a release edge must see a full hold count behind it
  AST_HOLD_FULL: assert property (@(posedge REF_CLK_IN) // RULE3
    disable iff (!RESET_N_IN)
    $rose(SYS_RESET_N_OUT) |-> hold_done)
    else $error("reset released before full hold");

  // the assert state always zeroes the hold count
  AST_ASSERT_CLEARS_HOLD: assert property (@(posedge REF_CLK_IN) // RULE4
    disable iff (!RESET_N_IN)
    state_r == supervisor_pkg::ST_ASSERT
    |=> hold_cnt_r == supervisor_pkg::CNT_ZERO)
    else $error("hold count not cleared by trigger");

  // an expiry alone leaves the reset released
  AST_WD_NO_RESET: assert property (@(posedge REF_CLK_IN) // RULE5
    disable iff (!RESET_N_IN)
    ($fell(WATCHDOG_EXPIRED_N_OUT) && !trigger &&
    state_r == supervisor_pkg::ST_RUN) |=> SYS_RESET_N_OUT)
    else $error("watchdog expiry asserted reset");

  // without a trigger the run state is kept
  AST_RUN_STABLE: assert property (@(posedge REF_CLK_IN) // RULE5
    disable iff (!RESET_N_IN)
    (state_r == supervisor_pkg::ST_RUN && !trigger)
    |=> state_r == supervisor_pkg::ST_RUN)
    else $error("run state left without trigger");

  // the active-high output tracks the generator state
  AST_OUT_STATE: assert property (@(posedge REF_CLK_IN) // RULE6
    disable iff (!RESET_N_IN)
    SYS_RESET_OUT == (state_r != supervisor_pkg::ST_RUN))
    else $error("active-high reset off its state");

  // a manual rising edge starts a hold, not a release
  AST_MR_RISE_HOLD: assert property (@(posedge REF_CLK_IN) // RULE3
    disable iff (!RESET_N_IN)
    ($rose(mr_n_s) && !supply_low_s) |=> !SYS_RESET_N_OUT)
    else $error("manual release dropped reset at once");

  // release only ever follows the hold state
  AST_NO_EARLY_RELEASE: assert property (@(posedge REF_CLK_IN) // RULE8
    disable iff (!RESET_N_IN)
    $rose(SYS_RESET_N_OUT) |-> $past(state_r) == supervisor_pkg::ST_HOLD)
    else $error("release without hold period");

  // hold count advances by one per tick
  AST_HOLD_STEP: assert property (@(posedge REF_CLK_IN) // RULE2
    disable iff (!RESET_N_IN)
    (state_r == supervisor_pkg::ST_HOLD && !trigger && !hold_done &&
    tick_r) |=> hold_cnt_r == $past(hold_cnt_r) + supervisor_pkg::CNT_ONE)
    else $error("hold count did not step on tick");

  // between ticks the hold count stands still
  AST_HOLD_NO_TICK: assert property (@(posedge REF_CLK_IN) // RULE19
    disable iff (!RESET_N_IN)
    (state_r == supervisor_pkg::ST_HOLD && !trigger && !tick_r)
    |=> $stable(hold_cnt_r))
    else $error("hold count moved without tick");

  // timebase pulses last a single cycle
  AST_TICK_PULSE: assert property (@(posedge REF_CLK_IN) // RULE19
    disable iff (!RESET_N_IN) tick_r |=> !tick_r)
    else $error("timebase pulse too long");

  // only the three coded states are ever reached
  AST_STATE_LEGAL: assert property (@(posedge REF_CLK_IN) // RULE4
    disable iff (!RESET_N_IN)
    state_r inside {supervisor_pkg::ST_ASSERT, supervisor_pkg::ST_HOLD,
    supervisor_pkg::ST_RUN})
    else $error("reset generator in illegal state");

  // watchdog: kick edges and floating pin clear the expiry
  AST_KICK_CLEAR: assert property (@(posedge REF_CLK_IN) // RULE12
    disable iff (!RESET_N_IN) kick_edge |=> !wd_done)
    else $error("kick edge did not clear watchdog");

  AST_FLOAT_CLEAR: assert property (@(posedge REF_CLK_IN) // RULE14
    disable iff (!RESET_N_IN) !kick_drv_s |=> !wd_done)
    else $error("floating kick let watchdog count");

  // expiry drives the flag low on the next edge
  AST_WD_LOW: assert property (@(posedge REF_CLK_IN) // RULE11
    disable iff (!RESET_N_IN) wd_done |=> !WATCHDOG_EXPIRED_N_OUT)
    else $error("expiry did not lower watchdog flag");

  // no hold delay once supply recovers and no expiry
  AST_WD_RECOVER: assert property (@(posedge REF_CLK_IN) // RULE16
    disable iff (!RESET_N_IN)
    (!supply_low_s && !wd_done) |=> WATCHDOG_EXPIRED_N_OUT)
    else $error("watchdog flag held low after recovery");

  // power-fail flag rises as soon as sense recovers
  AST_PFO_HIGH: assert property (@(posedge REF_CLK_IN) // RULE10
    disable iff (!RESET_N_IN) !pf_low_s |=> POWER_FAIL_FLAG_N_OUT)
    else $error("power-fail flag stuck low");

  COV_FLOAT: cover property (@(posedge REF_CLK_IN)
    disable iff (!RESET_N_IN)
    !kick_drv_s && state_r == supervisor_pkg::ST_RUN);
  COV_RELEASE: cover property (@(posedge REF_CLK_IN)
    disable iff (!RESET_N_IN) $rose(SYS_RESET_N_OUT));
  COV_EXPIRE: cover property (@(posedge REF_CLK_IN)
    disable iff (!RESET_N_IN) $fell(WATCHDOG_EXPIRED_N_OUT));
  COV_RETRIG: cover property (@(posedge REF_CLK_IN)
    disable iff (!RESET_N_IN)
    state_r == supervisor_pkg::ST_HOLD && trigger);
endmodule : supply_supervisor_reset_watchdog
`default_nettype wire

/* File: dv/supervisor_host_model.sv */
// host model: toggles or floats the watchdog kick line
`timescale 1ns/1ps
`default_nettype none
module supervisor_host_model (
  // clock
  input wire logic clk_in,
  // behaviour select from the bench
  input wire logic run_in,
  input wire logic float_in,
  // kick pin as seen by the supervisor
  output logic kick_out,
  output logic driven_out
);
  logic [4:0] gap_r = 5'h00;
  initial kick_out = 1'b0;
  initial driven_out = 1'b1;
  // toggle well inside the timeout; a floating pin holds still
  // so no edge can keep the watchdog alive behind its back
  always @(posedge clk_in) begin
    driven_out <= ~float_in;
    gap_r <= gap_r + 5'h01;
    if (!float_in && run_in && gap_r == 5'h13) begin
      kick_out <= ~kick_out;
    end
  end
endmodule : supervisor_host_model
`default_nettype wire

/* File: dv/supply_supervisor_reset_watchdog_test.sv */
// testbench for the supply supervisor
`timescale 1ns/1ps
`default_nettype none
module supply_supervisor_reset_watchdog_test;
  localparam int TICK = 4;
  localparam int HOLD = 40;
  localparam int WDOG = 80;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic sup_low = 1'b0;
  logic pf_low = 1'b0;
  logic mr_n = 1'b1;
  logic run = 1'b1;
  logic flt = 1'b0;
  logic kick, driven, res_n, res, wdo_n, pfo_n;
  int miscompares = 0;
  int num_checks = 0;
  int n;
  // 100 MHz clock
  always #5 clk = ~clk;
  supply_supervisor_reset_watchdog #(.TICK_CYCLES(TICK),
    .HOLD_CYCLES(HOLD), .WDOG_CYCLES(WDOG)) supply_supervisor_reset_watchdog_i (
    .REF_CLK_IN(clk), .RESET_N_IN(rst_n), .SUPPLY_LOW_IN(sup_low),
    .POWER_FAIL_SENSE_LOW_IN(pf_low), .MANUAL_RESET_N_INPUT_IN(mr_n),
    .WATCHDOG_KICK_INPUT_IN(kick), .WATCHDOG_KICK_DRIVEN_IN(driven),
    .SYS_RESET_N_OUT(res_n), .SYS_RESET_OUT(res),
    .WATCHDOG_EXPIRED_N_OUT(wdo_n), .POWER_FAIL_FLAG_N_OUT(pfo_n));
  supervisor_host_model supervisor_host_model_i (.clk_in(clk),
    .run_in(run), .float_in(flt), .kick_out(kick), .driven_out(driven));
  task automatic complete_run;
    $display("checks %0d mismatches %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : complete_run
  task automatic cyc(input int k);
    repeat (k) @(negedge clk);
  endtask : cyc
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("ERROR at %0t got %h exp %h", $time, got, exp);
    end
  endtask : check
  // bounded wait; sel 0 watches reset, 1 watches the watchdog flag
  task automatic wait_lvl(input bit sel, input logic v, input int bound,
    output int k);
    k = 0;
    while ((sel ? wdo_n : res_n) !== v && k < bound) begin
      cyc(1);
      k++;
    end
    if (k >= bound) begin
      miscompares++;
      $display("ERROR at %0t got %h exp %h", $time, ~v, v);
      complete_run();
    end
  endtask : wait_lvl
  // measured length must sit within two ticks and the sync delay of nominal
  task automatic in_range(input int k, input int lo, input int hi);
    check(32'(k >= lo && k <= hi), 32'h1);
  endtask : in_range
  task automatic t_power_on;
    check({res_n, res}, 32'h1);
    wait_lvl(1'b0, 1'b1, 4 * HOLD, n);
    in_range(n, HOLD - 2 * TICK, HOLD + 3 + 2 * TICK);
    check(res, 32'h0);
    check(wdo_n, 32'h1);
  endtask : t_power_on
  task automatic t_manual;
    mr_n = 1'b0;
    cyc(3);
    mr_n = 1'b1;
    check({res_n, res}, 32'h1);
    wait_lvl(1'b0, 1'b1, 4 * HOLD, n);
    in_range(n, HOLD - 2 * TICK, HOLD + 3 + 2 * TICK);
  endtask : t_manual
  task automatic t_restart;
    sup_low = 1'b1;
    cyc(5);
    check({res_n, res, wdo_n}, 32'h2);
    sup_low = 1'b0;
    cyc(4);
    check({res_n, wdo_n}, 32'h1);
    cyc(HOLD / 2 - 4);
    mr_n = 1'b0;
    cyc(2);
    mr_n = 1'b1;
    wait_lvl(1'b0, 1'b1, 4 * HOLD, n);
    in_range(n, HOLD - 2 * TICK, HOLD + 3 + 2 * TICK);
  endtask : t_restart
  task automatic t_watchdog;
    run = 1'b0;
    t_manual();
    wait_lvl(1'b1, 1'b0, 4 * WDOG, n);
    in_range(n, WDOG - 2 * TICK, WDOG + 3 + 2 * TICK);
    cyc(WDOG);
    check({res_n, wdo_n}, 32'h2);
    run = 1'b1;
    wait_lvl(1'b1, 1'b1, 40, n);
    cyc(3 * WDOG);
    check({res_n, wdo_n}, 32'h3);
  endtask : t_watchdog
  task automatic t_float;
    flt = 1'b1;
    cyc(3 * WDOG);
    check(wdo_n, 32'h1);
    flt = 1'b0;
  endtask : t_float
  task automatic t_power_fail;
    pf_low = 1'b1;
    cyc(4);
    check({pfo_n, res_n}, 32'h1);
    pf_low = 1'b0;
    cyc(4);
    check(pfo_n, 32'h1);
  endtask : t_power_fail
  // main sequence
  initial begin
    cyc(8);
    rst_n = 1'b1;
    cyc(1);
    t_power_on();
    t_manual();
    t_restart();
    t_watchdog();
    t_float();
    t_power_fail();
    complete_run();
  end
endmodule : supply_supervisor_reset_watchdog_test
`default_nettype wire
